// File: rtl/scrp_read_port.v
// scrp_read_port.v : two-wire serial control read port with
// attention request, plus its outgoing message fifo
// assumes: one clock ref_clk; serial clock and data arrive
// asynchronously from the host and are sampled here
`timescale 1ns/1ns
`default_nettype none
`include "scrp_consts.vh"

// ****************************************
// message fifo
// ****************************************
module scrp_fifo #(
   parameter WIDTH = `SCRP_FIFO_WIDTH,
   parameter DEPTH = `SCRP_FIFO_DEPTH,
   parameter AW    = `SCRP_FIFO_AW
) (
   input  wire             ref_clk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            do_wr;
   wire            do_rd;

   // honest full and empty from the fill count
   assign in_ready  = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data  = mem_ff[rd_ptr_ff];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   // pointers, count and storage write
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            mem_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (do_wr & ~do_rd) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_rd & ~do_wr) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // scrp_fifo

// ****************************************
// read port top
// ****************************************
module scrp_read_port #(
   parameter FIFO_DEPTH = `SCRP_FIFO_DEPTH,
   parameter FIFO_AW    = `SCRP_FIFO_AW
) (
   input  wire       ref_clk,
   input  wire       reset_n,
   input  wire       control_serial_clock,
   input  wire       control_serial_data_in,
   output wire       control_serial_data_out,
   output wire       control_serial_data_oe_n,
   output wire       host_attention_request_n,
   input  wire [7:0] msg_data,
   input  wire       msg_valid,
   output wire       msg_ready,
   input  wire       unsolicited_enable,
   input  wire       read_request,
   input  wire       four_wire_mode,
   output wire [7:0] rx_data,
   output wire       rx_strobe
);
   // one-hot link states
   localparam ST_IDLE = 7'b0000001;
   localparam ST_ADDR = 7'b0000010;
   localparam ST_AACK = 7'b0000100;
   localparam ST_TX   = 7'b0001000;
   localparam ST_RACK = 7'b0010000;
   localparam ST_RX   = 7'b0100000;
   localparam ST_WACK = 7'b1000000;

   reg  [2:0] scl_sync_ff;
   reg  [2:0] sda_sync_ff;
   reg        scl_ff;
   reg        sda_ff;
   reg  [6:0] state_ff;
   reg  [2:0] bit_cnt_ff;
   reg        byte_done_ff;
   reg  [7:0] rx_sh_ff;
   reg  [7:0] tx_sh_ff;
   reg        rw_ff;
   reg        drive_low_ff;
   reg        host_ack_ff;
   reg  [7:0] rx_data_ff;
   reg        rx_strobe_ff;
   reg        attn_n_ff;
   reg        hold_high_ff;
   reg        armed_ff;
   reg        filler_ff;
   reg        pop_ff;
   wire       scl_new;
   wire       sda_new;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_cond;
   wire       stop_cond;
   wire       allowed;
   wire       n1_edge;
   wire       n_edge;
   wire       tx_load;
   wire [7:0] fifo_data;
   wire       fifo_valid;
   wire [7:0] next_tx;

   // ****************************************
   // outgoing message fifo
   // ****************************************
   scrp_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .in_data   (msg_data),
      .in_valid  (msg_valid),
      .in_ready  (msg_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (pop_ff)
   );

   // ****************************************
   // pin sampling and bus conditions
   // ****************************************
   // three stages; the filtered level moves when stages 2 and 3 agree
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         scl_sync_ff <= 3'h0;
         sda_sync_ff <= 3'h7;
         scl_ff      <= 1'b0;
         sda_ff      <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], control_serial_clock};
         sda_sync_ff <= {sda_sync_ff[1:0], control_serial_data_in};
         scl_ff      <= scl_new;
         sda_ff      <= sda_new;
      end
   end

   assign scl_new    = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
   assign sda_new    = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
   assign scl_rise   = ~scl_ff & scl_new;
   assign scl_fall   = scl_ff & ~scl_new;
   assign start_cond = scl_ff & scl_new & sda_ff & ~sda_new;
   assign stop_cond  = scl_ff & scl_new & ~sda_ff & sda_new;

   // ****************************************
   // attention edges
   // ****************************************
   // clock N-1 and clock N of the byte being sent
   assign n1_edge = scl_rise & state_ff[3] &
                    (bit_cnt_ff == (four_wire_mode ? `SCRP_BIT_ONE : `SCRP_BIT_LSB));
   assign n_edge  = scl_rise & ((four_wire_mode & state_ff[3] & (bit_cnt_ff == `SCRP_BIT_LSB)) |
                    (~four_wire_mode & state_ff[4]));
   assign allowed = unsolicited_enable | armed_ff;
   assign tx_load = scl_fall & ((state_ff[2] & (rw_ff == `SCRP_RW_READ)) | (state_ff[4] & host_ack_ff)); // shifter loads

   // next byte to shift: filler first when a late message was flagged
   assign next_tx = filler_ff ? `SCRP_FILLER_BYTE :
                    (fifo_valid ? fifo_data : `SCRP_EMPTY_BYTE);

   // ****************************************
   // attention request line
   // ****************************************
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         attn_n_ff    <= 1'b1;
         hold_high_ff <= 1'b0;
         armed_ff     <= 1'b0;
         filler_ff    <= 1'b0;
      end else begin
         // a read request arms solicited mode
         if (read_request) begin
            armed_ff <= 1'b1;
         end
         if (n1_edge & ~attn_n_ff & ~fifo_valid) begin
            attn_n_ff    <= 1'b1;
            hold_high_ff <= 1'b1;
            armed_ff     <= read_request;
         end else if (n_edge & hold_high_ff) begin
            // late message drops the line at clock N and needs a filler
            hold_high_ff <= 1'b0;
            if (allowed & fifo_valid) begin
               attn_n_ff <= 1'b0;
               filler_ff <= 1'b1;
            end
         end else if (~hold_high_ff & allowed & fifo_valid) begin
            attn_n_ff <= 1'b0;
         end
         // stop before the next read means the message loads directly
         if (stop_cond) begin
            filler_ff    <= 1'b0;
            hold_high_ff <= 1'b0;
         end else if (tx_load & filler_ff) begin
            filler_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // serial byte engine
   // ****************************************
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         state_ff     <= ST_IDLE;
         bit_cnt_ff   <= `SCRP_BIT_MSB;
         byte_done_ff <= 1'b0;
         rx_sh_ff     <= 8'h00;
         tx_sh_ff     <= 8'hFF;
         rw_ff        <= 1'b0;
         drive_low_ff <= 1'b0;
         host_ack_ff  <= 1'b0;
         rx_data_ff   <= 8'h00;
         rx_strobe_ff <= 1'b0;
         pop_ff       <= 1'b0;
      end else begin
         rx_strobe_ff <= 1'b0;
         pop_ff       <= 1'b0;
         if (start_cond) begin
            state_ff     <= ST_ADDR;
            bit_cnt_ff   <= `SCRP_BIT_MSB;
            byte_done_ff <= 1'b0;
            drive_low_ff <= 1'b0;
         end else if (stop_cond) begin
            state_ff     <= ST_IDLE;
            drive_low_ff <= 1'b0;
         end else begin
            case (state_ff)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     rx_sh_ff     <= {rx_sh_ff[6:0], sda_ff};
                     byte_done_ff <= (bit_cnt_ff == `SCRP_BIT_LSB);
                     bit_cnt_ff   <= bit_cnt_ff - 1'b1;
                  end else if (scl_fall & byte_done_ff) begin
                     byte_done_ff <= 1'b0;
                     if (state_ff[5]) begin
                        // written byte: hand it on and acknowledge
                        rx_data_ff   <= rx_sh_ff;
                        rx_strobe_ff <= 1'b1;
                        drive_low_ff <= 1'b1;
                        state_ff     <= ST_WACK;
                     end else if (rx_sh_ff[7:1] == `SCRP_DEV_ADDR) begin
                        rw_ff        <= rx_sh_ff[0];
                        drive_low_ff <= 1'b1;
                        state_ff     <= ST_AACK;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= `SCRP_BIT_MSB;
                     if (rw_ff == `SCRP_RW_READ) begin
                        tx_sh_ff     <= next_tx;
                        pop_ff       <= ~filler_ff & fifo_valid;
                        drive_low_ff <= ~next_tx[7];
                        state_ff     <= ST_TX;
                     end else begin
                        drive_low_ff <= 1'b0;
                        state_ff     <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  // bits move only on falling edges
                  if (scl_fall) begin
                     if (bit_cnt_ff == `SCRP_BIT_LSB) begin
                        drive_low_ff <= 1'b0;
                        state_ff     <= ST_RACK;
                     end else begin
                        tx_sh_ff     <= {tx_sh_ff[6:0], 1'b1};
                        drive_low_ff <= ~tx_sh_ff[6];
                        bit_cnt_ff   <= bit_cnt_ff - 1'b1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     host_ack_ff <= ~sda_ff;
                  end else if (scl_fall) begin
                     if (host_ack_ff) begin
                        tx_sh_ff     <= next_tx;
                        pop_ff       <= ~filler_ff & fifo_valid;
                        drive_low_ff <= ~next_tx[7];
                        bit_cnt_ff   <= `SCRP_BIT_MSB;
                        state_ff     <= ST_TX;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_WACK: begin
                  if (scl_fall) begin
                     drive_low_ff <= 1'b0;
                     bit_cnt_ff   <= `SCRP_BIT_MSB;
                     state_ff     <= ST_RX;
                  end
               end
               default: begin
                  drive_low_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // open-drain data: only ever drives low, enable active low
   assign control_serial_data_out  = 1'b0;
   assign control_serial_data_oe_n = ~drive_low_ff;
   assign host_attention_request_n = attn_n_ff;
   assign rx_data                  = rx_data_ff;
   assign rx_strobe                = rx_strobe_ff;
endmodule // scrp_read_port
`default_nettype wire

// File: rtl/scrp_consts.vh
// scrp_consts.vh : constants for the serial control read port
// assumes: included by bare name from rtl/scrp_read_port.v
`ifndef SCRP_CONSTS_VH
`define SCRP_CONSTS_VH

// ****************************************
// bus addressing
// ****************************************
`define SCRP_DEV_ADDR    7'h00
`define SCRP_RW_READ     1'b1

// ****************************************
// byte values
// ****************************************
`define SCRP_FILLER_BYTE 8'h00
`define SCRP_EMPTY_BYTE  8'hFF

// ****************************************
// bit counter and fifo defaults
// ****************************************
`define SCRP_BIT_MSB     3'h7
`define SCRP_BIT_LSB     3'h0
`define SCRP_BIT_ONE     3'h1
`define SCRP_FIFO_WIDTH  8
`define SCRP_FIFO_DEPTH  16
`define SCRP_FIFO_AW     4

`endif

// File: sim/scrp_read_port_sva.sv
// checker: link and attention timing at the read port pins
// assumes: bound to scrp_read_port by the bench top file
`timescale 1ns/1ns
`default_nettype none
module scrp_read_port_sva (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic control_serial_clock,
   input wire logic control_serial_data_in,
   input wire logic control_serial_data_oe_n,
   input wire logic host_attention_request_n,
   input wire logic msg_valid,
   input wire logic msg_ready,
   input wire logic unsolicited_enable,
   input wire logic read_request,
   input wire logic rx_strobe
);
   logic       scl_ff, sda_ff, att_ff, held_ff, armed_ff, frame_ff;
   logic [3:0] fall_ff, rise_ff;
   wire        att      = host_attention_request_n;
   wire        oe_n     = control_serial_data_oe_n;
   wire        scl_fall = scl_ff & ~control_serial_clock;
   wire        scl_rise = ~scl_ff & control_serial_clock;
   wire        att_rise = att & ~att_ff;
   // edge ages, frame state, hold window and solicited arming
   always @(posedge ref_clk) begin
      scl_ff <= control_serial_clock;
      sda_ff <= control_serial_data_in;
      att_ff <= att;
      if (!reset_n) begin
         fall_ff  <= 4'hF;
         rise_ff  <= 4'hF;
         held_ff  <= 1'b0;
         armed_ff <= 1'b0;
         frame_ff <= 1'b0;
      end else begin
         fall_ff  <= scl_fall ? 4'h0 : fall_ff + {3'h0, fall_ff != 4'hF};
         rise_ff  <= scl_rise ? 4'h0 : rise_ff + {3'h0, rise_ff != 4'hF};
         held_ff  <= att_rise | (held_ff & ~scl_rise);
         armed_ff <= read_request | (armed_ff & ~att_rise);
         if (scl_ff & control_serial_clock & (sda_ff ^ control_serial_data_in))
            frame_ff <= sda_ff; // start sets, stop clears
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_after_fall; fall_ff <= 4'h8; endsequence
   sequence s_one_pulse; s_after_fall ##1 !rx_strobe; endsequence
   a_data_after_fall: assert property ($changed(oe_n) |-> s_after_fall) else $error("data moved late");
   a_data_clock_low: assert property ($changed(oe_n) |-> !control_serial_clock) else $error("data moved high");
   a_release_idle: assert property (!frame_ff |-> oe_n) else $error("line held idle");
   a_ack_stands: assert property ($fell(oe_n) |=> !oe_n [*8]) else $error("low bit short");
   a_att_rise_edge: assert property ($rose(att) |-> rise_ff <= 4'h8) else $error("att rose off edge");
   a_att_hold: assert property (held_ff |-> att) else $error("att fell early");
   a_solicit_gate: assert property ($fell(att) |-> unsolicited_enable || armed_ff) else $error("att unasked");
   a_strobe_pulse: assert property (rx_strobe |-> s_one_pulse) else $error("strobe bad");
   a_ready_on_push: assert property ($fell(msg_ready) |-> $past(msg_valid)) else $error("ready fell alone");
endmodule // scrp_read_port_sva
`default_nettype wire

// File: sim/scrp_host_model.sv
// host model: two-wire bus master reading and writing the port
// assumes: bench resolves the open-drain line, pull-up high
`timescale 1ns/1ns
`default_nettype none
module scrp_host_model (
   input  wire logic ref_clk,
   input  wire logic line,
   output var  logic scl,
   output var  logic sda
);
   // clock idles low, data released
   initial scl = 1'b0;
   initial sda = 1'b1;
   // wait n reference cycles, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // start: data falls while clock is high
   task automatic start();
      scl = 1'b1;
      tick(10);
      sda = 1'b0;
      tick(10);
      scl = 1'b0;
   endtask
   // stop: data rises while clock is high, clock then stands
   task automatic stop();
      tick(5);
      sda = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(10);
      sda = 1'b1;
      tick(10);
   endtask
   // one bit: data set in the low phase, line read before the fall
   task automatic bit_x(input logic b, output logic r);
      tick(5);
      sda = b;
      tick(5);
      scl = 1'b1;
      tick(10);
      r = line;
      scl = 1'b0;
   endtask
   // one byte msb first, then the ninth clock
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bit_x(tx[i], rx[i]);
      bit_x(ack_in, ack_out);
   endtask
endmodule // scrp_host_model
`default_nettype wire

// File: sim/serial_control_read_port_bench.sv
// bench: reads, writes and attention timing of the read port
// assumes: host model masters the link, data line has a pull-up
`timescale 1ns/1ns
`default_nettype none
module serial_control_read_port_bench;
   logic       ref_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [7:0] msg_data = 8'h00;
   logic       msg_valid = 1'b0;
   logic       unsol = 1'b0;
   logic       read_request = 1'b0;
   logic       four_wire = 1'b0;
   logic [7:0] rx, b, p;
   logic       ack;
   logic [7:0] tx_q[$];
   logic [7:0] exp_q[$];
   wire        scl, sda, line, oe_n, att, ready, dout, strobe;
   int         strobes = 0;
   wire  [7:0] rx_data;
   int         miscompares = 0;
   int         check_count = 0;
   int         seed = 32'h6C9C;
   int         kind;
   always #4 ref_clk = ~ref_clk;
   assign line = oe_n & sda; // open drain, pulled up when released
   // count written-byte strobes
   always @(posedge ref_clk) begin
      if (strobe)
         strobes <= strobes + 1;
   end
   scrp_host_model scrp_host_model_inst (.ref_clk(ref_clk), .line(line), .scl(scl), .sda(sda));
   scrp_read_port scrp_read_port_inst (.ref_clk(ref_clk), .reset_n(reset_n), .control_serial_clock(scl),
      .control_serial_data_in(line), .control_serial_data_out(dout), .control_serial_data_oe_n(oe_n),
      .host_attention_request_n(att), .msg_data(msg_data), .msg_valid(msg_valid), .msg_ready(ready),
      .unsolicited_enable(unsol), .read_request(read_request), .four_wire_mode(four_wire),
      .rx_data(rx_data), .rx_strobe(strobe));
   // random byte; a leading message byte is never zero
   function automatic logic [7:0] rnd(input logic lead);
      rnd = 8'($random(seed));
      if (lead && rnd == 8'h00)
         rnd = 8'h5A;
   endfunction
   // clock rises before the push: ahead of n-1, or just past it
   function automatic int edges(input int k, input logic fw);
      return (fw ? 6 : 7) + ((k != 0) ? 1 : 0);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic chkb(input string w, input logic s, input logic e);
      chk(w, {7'h0, s}, {7'h0, e});
   endtask
   // back to back pushes of the queued bytes
   task automatic push_all();
      msg_valid = 1'b1;
      foreach (tx_q[i]) begin
         msg_data = tx_q[i];
         cyc(1);
      end
      msg_valid = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] t, input logic a);
      scrp_host_model_inst.xfer(t, a, rx, ack);
   endtask
   // start plus address byte, then the address acknowledge
   task automatic open(input logic [7:0] adr, input logic e);
      scrp_host_model_inst.start();
      xfer(adr, 1'b1);
      chkb("addr ack", ack, e);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // run limit: a hang counts as a mismatch
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      cyc(4);
      chkb("reset att", att, 1'b1);
      chkb("reset oe", oe_n, 1'b1);
      chkb("data out", dout, 1'b0);
      reset_n = 1'b1;
      cyc(8);
      for (int i = 0; i < 17; i++)
         tx_q.push_back(rnd(i == 0));
      exp_q = tx_q[0:15];
      push_all();
      chkb("full", ready, 1'b0);
      chkb("no request", att, 1'b1);
      read_request = 1'b1;
      cyc(1);
      read_request = 1'b0;
      cyc(3);
      chkb("att low", att, 1'b0);
      open(8'h01, 1'b0);
      for (int i = 0; i < 16; i++) begin
         xfer(8'hFF, i == 15);
         chk("data", rx, exp_q.pop_front());
         chkb("att", att, i == 15);
      end
      scrp_host_model_inst.stop();
      chkb("drained", ready, 1'b1);
      cyc(20);
      chkb("stays high", att, 1'b1);
      open(8'h03, 1'b1);
      scrp_host_model_inst.stop();
      open(8'h01, 1'b0);
      xfer(8'hFF, 1'b1);
      chk("empty", rx, 8'hFF);
      scrp_host_model_inst.stop();
      open(8'h00, 1'b0);
      b = rnd(1'b0);
      xfer(b, 1'b1);
      chkb("write ack", ack, 1'b0);
      chk("written", rx_data, b);
      chk("strobes", 8'(strobes), 8'h01);
      scrp_host_model_inst.stop();
      unsol = 1'b1;
      for (int m = 0; m < 6; m++) begin
         kind = m / 2;
         four_wire = m[0];
         tx_q = {rnd(1'b1), rnd(1'b0)};
         exp_q = tx_q;
         push_all();
         cyc(2);
         chkb("unsolicited", att, 1'b0);
         open(8'h01, 1'b0);
         xfer(8'hFF, 1'b0);
         chk("first", rx, exp_q[0]);
         p = rnd(1'b1);
         tx_q = {p};
         fork
            xfer(8'hFF, kind == 2);
            begin
               repeat (edges(kind, four_wire)) @(posedge scl);
               cyc(6);
               chkb("pulse", att, kind != 0);
               push_all();
            end
         join
         chk("last", rx, exp_q[1]);
         chkb("att again", att, 1'b0);
         if (kind == 2) begin
            scrp_host_model_inst.stop();
            open(8'h01, 1'b0);
         end
         if (kind == 1) begin
            xfer(8'hFF, 1'b0);
            chk("filler", rx, 8'h00);
         end
         xfer(8'hFF, 1'b1);
         chk("next", rx, p);
         scrp_host_model_inst.stop();
         cyc(20);
         chkb("idle", att, 1'b1);
      end
      report_and_stop();
   end
endmodule // serial_control_read_port_bench
bind scrp_read_port scrp_read_port_sva scrp_read_port_sva_inst (.ref_clk(ref_clk), .reset_n(reset_n),
   .control_serial_clock(control_serial_clock), .control_serial_data_in(control_serial_data_in),
   .control_serial_data_oe_n(control_serial_data_oe_n), .host_attention_request_n(host_attention_request_n),
   .msg_valid(msg_valid), .msg_ready(msg_ready), .unsolicited_enable(unsolicited_enable),
   .read_request(read_request), .rx_strobe(rx_strobe));
`default_nettype wire
